/* inc/sdr_pkg.sv */
// Constants, types and register map for the supply drop reset control block
// How it works
// - Supply-drop detection stays active in fast and slow modes.
// - Detection is off in idle or sleep; no supply-drop reset there.
// - Reset only when low supply persists beyond the selected width.
// - Width code selects 7-8, 31-32, 63-64 or 127-128 oscillator periods.
// - Only 0x55, 0x33, 0x99, 0xaa are valid threshold codes, rising.
// - Invalid threshold code: reset after soft delay, register back to 0x55.
// - Invalid threshold code reset sets the invalid-code flag.
// - Qualified low-supply reset sets the supply-drop flag.
// - Hardware never clears those flags; software writes zero to clear.
// - Supply-drop reset leaves the threshold register unchanged.
// - Power-on loads threshold register with 0x55.
// - Watchdog timeout in fast or slow: full reset, timeout flag set.
// - Watchdog timeout in idle or sleep: PC and SP clear, both flags set.
// - Power-on clears timeout and power-down; supply-drop reset keeps them.
// - Power-on: PC zero, interrupts off, timers off, ports input, SP top, watchdog restart.
// - Pointers cleared on power-on and normal watchdog, kept on sleep watchdog.
// - Filter periods counted on the low-speed oscillator, about 32 kHz.
package sdr_pkg;
  localparam logic [11:0] ADDR_THRESH   = 12'h000;
  localparam logic [11:0] ADDR_WIDTH    = 12'h004;
  localparam logic [11:0] ADDR_FLAGS    = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h010;
  localparam logic [11:0] ADDR_IRQ_CLR  = 12'h014;
  localparam logic [11:0] ADDR_STATUS   = 12'h018;

  localparam logic [7:0] THRESH_RESET = 8'h55;
  localparam logic [7:0] THRESH_V0    = 8'h55;
  localparam logic [7:0] THRESH_V1    = 8'h33;
  localparam logic [7:0] THRESH_V2    = 8'h99;
  localparam logic [7:0] THRESH_V3    = 8'haa;
  localparam logic [1:0] WIDTH_RESET  = 2'h1;

  localparam int FLAG_WDOG_BIT    = 0;
  localparam int FLAG_INVALID_BIT = 1;
  localparam int FLAG_DROP_BIT    = 2;
  localparam int STAT_TO_BIT      = 0;
  localparam int STAT_PDF_BIT     = 1;

  // Widths in oscillator periods; count the upper figure so the window is 7~8 etc.
  localparam logic [7:0] WIDTH_P0 = 8'h08;
  localparam logic [7:0] WIDTH_P1 = 8'h20;
  localparam logic [7:0] WIDTH_P2 = 8'h40;
  localparam logic [7:0] WIDTH_P3 = 8'h80;

  // Soft reset delay in oscillator periods (no figure given)
  localparam logic [7:0] SOFT_RESET_DELAY = 8'h04;
  // Reset pulse length in clock cycles
  localparam logic [3:0] RESET_PULSE = 4'h4;

  typedef enum logic [1:0] {
    MODE_FAST  = 2'b00,
    MODE_SLOW  = 2'b01,
    MODE_IDLE  = 2'b10,
    MODE_SLEEP = 2'b11
  } op_mode_t;

  typedef enum logic [2:0] {
    RST_NONE    = 3'b000,
    RST_POWERON = 3'b001,
    RST_DROP    = 3'b010,
    RST_INVALID = 3'b011,
    RST_WDOG    = 3'b100,
    RST_WDOG_HLT= 3'b101
  } rst_kind_t;
endpackage

/* inc/sdr_evt_if.sv */
// Event carrier between the filter, the code checker and the controller
`timescale 1ns/1ps
`default_nettype none
interface sdr_evt_if;
  logic qualified_drop;
  logic invalid_reset;
  modport src (output qualified_drop, output invalid_reset);
  modport dst (input qualified_drop, input invalid_reset);
endinterface
`default_nettype wire

/* hw/sdr_drop_filter.sv */
// Persistence filter on the synchronised low-supply indication
`timescale 1ns/1ps
`default_nettype none
module sdr_drop_filter
  import sdr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       low_supply,
  input  wire logic       detect_en,
  input  wire logic [1:0] width_code,
  output logic            qualified_drop
);
  logic       sync1_r;
  logic       sync2_r;
  logic [7:0] count_r;
  logic [7:0] limit;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= low_supply;
      sync2_r <= sync1_r;
    end
  end

  always_comb begin
    case (width_code)
      2'b00:   limit = WIDTH_P0;
      2'b01:   limit = WIDTH_P1;
      2'b10:   limit = WIDTH_P2;
      default: limit = WIDTH_P3;
    endcase
  end

  // Clock is the low-speed oscillator itself, so each edge is one period
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_r <= 8'h00;
    end else if (!sync2_r || !detect_en) begin
      count_r <= 8'h00;
    end else if (count_r < limit) begin
      count_r <= count_r + 8'h01;
    end
  end

  // Saturating compare: a smaller width written mid-dip must not let the counter wrap
  assign qualified_drop = detect_en && (count_r >= limit);

  property p_drop_needs_persist;
    @(posedge clock) disable iff (!reset_n)
      qualified_drop |-> $past(sync2_r, 7);
  endproperty
  a_drop_needs_persist: assert property (p_drop_needs_persist)
    else $error("drop qualified without persistent low supply");

  property p_restart;
    @(posedge clock) disable iff (!reset_n)
      !sync2_r |=> count_r == 8'h00;
  endproperty
  a_restart: assert property (p_restart)
    else $error("counter did not restart");
endmodule // sdr_drop_filter
`default_nettype wire

/* hw/sdr_code_check.sv */
// Threshold code validity check with soft reset delay
`timescale 1ns/1ps
`default_nettype none
module sdr_code_check
  import sdr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] code,
  output logic            code_valid,
  output logic            invalid_reset
);
  logic [7:0] delay_r;

  assign code_valid = (code == THRESH_V0) || (code == THRESH_V1) ||
                      (code == THRESH_V2) || (code == THRESH_V3);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      delay_r <= 8'h00;
    end else if (code_valid) begin
      delay_r <= 8'h00;
    end else if (delay_r != SOFT_RESET_DELAY) begin
      delay_r <= delay_r + 8'h01;
    end
  end

  assign invalid_reset = !code_valid && (delay_r == SOFT_RESET_DELAY);

  property p_invalid_delay;
    @(posedge clock) disable iff (!reset_n)
      invalid_reset |-> $past(!code_valid, 4);
  endproperty
  a_invalid_delay: assert property (p_invalid_delay)
    else $error("invalid reset before soft delay");
endmodule // sdr_code_check
`default_nettype wire

/* hw/supply_drop_reset_control.sv */
// Supply drop reset control: filter, code check, reset cause flags, APB registers
`timescale 1ns/1ps
`default_nettype none
module supply_drop_reset_control
  import sdr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        low_supply,
  input  wire logic [1:0]  op_mode,
  input  wire logic        wdog_timeout,
  output logic             chip_reset,
  output logic             core_clear,
  output logic             pointer_clear,
  output logic             power_on_init,
  output logic [2:0]       reset_kind,
  output logic             timeout_flag,
  output logic             power_down_flag,
  output logic [1:0]       threshold_level,
  output logic             irq
);
  sdr_evt_if evt ();

  logic [7:0] threshold_code_r;
  logic [1:0] width_code_r;
  logic [2:0] flags_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_en_r;
  logic       timeout_flag_r;
  logic       power_down_flag_r;
  logic       por_done_r;
  logic [3:0] pulse_r;
  logic [2:0] kind_r;
  logic       halted;
  logic       detect_en;
  logic       code_valid;
  logic       drop_evt;
  logic       invalid_evt;
  logic       wdog_run;
  logic       wdog_halt;
  logic       busy;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [2:0] evt_vec;
  logic [2:0] flag_clr;
  logic [2:0] irq_clr;

  assign halted    = (op_mode == MODE_IDLE) || (op_mode == MODE_SLEEP);
  assign detect_en = !halted;

  sdr_drop_filter u_filter (
    .clock          (clock),
    .reset_n        (reset_n),
    .low_supply     (low_supply),
    .detect_en      (detect_en),
    .width_code     (width_code_r),
    .qualified_drop (evt.qualified_drop)
  );

  sdr_code_check u_check (
    .clock         (clock),
    .reset_n       (reset_n),
    .code          (threshold_code_r),
    .code_valid    (code_valid),
    .invalid_reset (evt.invalid_reset)
  );

  // A reset pulse in progress masks new causes so each event yields one pulse
  assign busy        = (pulse_r != 4'h0);
  assign drop_evt    = evt.qualified_drop && !busy;
  assign invalid_evt = evt.invalid_reset && !busy && !drop_evt;
  assign wdog_run    = wdog_timeout && !halted && !busy && !drop_evt && !invalid_evt;
  assign wdog_halt   = wdog_timeout && halted && !busy;

  // APB: zero wait states, errors on unmapped addresses
  assign pready  = 1'b1;
  assign addr_ok = (paddr == ADDR_THRESH) || (paddr == ADDR_WIDTH) ||
                   (paddr == ADDR_FLAGS) || (paddr == ADDR_IRQ_STAT) ||
                   (paddr == ADDR_IRQ_EN) || (paddr == ADDR_IRQ_CLR) ||
                   (paddr == ADDR_STATUS);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_en   = psel && !penable && !pwrite;

  // Threshold register; hardware reload only on an invalid-code reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      threshold_code_r <= THRESH_RESET;
    end else if (invalid_evt) begin
      threshold_code_r <= THRESH_RESET;
    end else if (wr_en && (paddr == ADDR_THRESH)) begin
      threshold_code_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      width_code_r <= WIDTH_RESET;
    end else if (wr_en && (paddr == ADDR_WIDTH)) begin
      width_code_r <= pwdata[1:0];
    end
  end

  assign evt_vec  = {drop_evt, invalid_evt, 1'b0};
  assign flag_clr = (wr_en && (paddr == ADDR_FLAGS)) ? ~pwdata[2:0] : 3'b000;

  // Flags only fall on a software write of zero; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flags_r <= 3'b000;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | evt_vec;
    end
  end

  assign irq_clr = (wr_en && (paddr == ADDR_IRQ_CLR)) ? pwdata[2:0] : 3'b000;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_stat_r <= 3'b000;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | {drop_evt, invalid_evt, wdog_run | wdog_halt};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_en_r <= 3'b000;
    end else if (wr_en && (paddr == ADDR_IRQ_EN)) begin
      irq_en_r <= pwdata[2:0];
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // Timeout and power-down flags; supply-drop and invalid resets leave them alone
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      timeout_flag_r    <= 1'b0;
      power_down_flag_r <= 1'b0;
    end else if (wdog_halt) begin
      timeout_flag_r    <= 1'b1;
      power_down_flag_r <= 1'b1;
    end else if (wdog_run) begin
      timeout_flag_r    <= 1'b1;
    end
  end

  // Reset pulse generator and cause record
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pulse_r <= RESET_PULSE;
      kind_r  <= RST_POWERON;
    end else if (drop_evt) begin
      pulse_r <= RESET_PULSE;
      kind_r  <= RST_DROP;
    end else if (invalid_evt) begin
      pulse_r <= RESET_PULSE;
      kind_r  <= RST_INVALID;
    end else if (wdog_run) begin
      pulse_r <= RESET_PULSE;
      kind_r  <= RST_WDOG;
    end else if (wdog_halt) begin
      pulse_r <= RESET_PULSE;
      kind_r  <= RST_WDOG_HLT;
    end else if (busy) begin
      pulse_r <= pulse_r - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      por_done_r <= 1'b0;
    end else if (!busy) begin
      por_done_r <= 1'b1;
    end
  end

  // Halted watchdog reset clears only PC and SP, so no chip reset for it
  assign chip_reset    = busy && (kind_r != RST_WDOG_HLT);
  assign core_clear    = busy;
  assign pointer_clear = busy && ((kind_r == RST_POWERON) || (kind_r == RST_WDOG) ||
                                  (kind_r == RST_DROP) || (kind_r == RST_INVALID));
  assign power_on_init = busy && !por_done_r;
  assign reset_kind    = busy ? kind_r : RST_NONE;
  assign timeout_flag    = timeout_flag_r;
  assign power_down_flag = power_down_flag_r;

  always_comb begin
    case (threshold_code_r)
      THRESH_V1: threshold_level = 2'h1;
      THRESH_V2: threshold_level = 2'h2;
      THRESH_V3: threshold_level = 2'h3;
      default:   threshold_level = 2'h0;
    endcase
  end

  // Read data captured in setup phase, valid in access phase
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == ADDR_THRESH) begin
        prdata <= {24'h00_0000, threshold_code_r};
      end else if (paddr == ADDR_WIDTH) begin
        prdata <= {30'h0000_0000, width_code_r};
      end else if (paddr == ADDR_FLAGS) begin
        prdata <= {29'h0000_0000, flags_r};
      end else if (paddr == ADDR_IRQ_STAT) begin
        prdata <= {29'h0000_0000, irq_stat_r};
      end else if (paddr == ADDR_IRQ_EN) begin
        prdata <= {29'h0000_0000, irq_en_r};
      end else if (paddr == ADDR_STATUS) begin
        prdata <= {30'h0000_0000, power_down_flag_r, timeout_flag_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  property p_no_drop_halted;
    @(posedge clock) disable iff (!reset_n)
      halted |-> !drop_evt;
  endproperty
  a_no_drop_halted: assert property (p_no_drop_halted)
    else $error("supply-drop reset while halted");

  property p_drop_flag;
    @(posedge clock) disable iff (!reset_n)
      drop_evt |=> flags_r[FLAG_DROP_BIT] && chip_reset;
  endproperty
  a_drop_flag: assert property (p_drop_flag)
    else $error("supply-drop flag not set");

  property p_invalid_flag;
    @(posedge clock) disable iff (!reset_n)
      invalid_evt |=> flags_r[FLAG_INVALID_BIT] && threshold_code_r == THRESH_RESET;
  endproperty
  a_invalid_flag: assert property (p_invalid_flag)
    else $error("invalid-code flag or reload missing");

  property p_flag_sticky;
    @(posedge clock) disable iff (!reset_n)
      $fell(flags_r[FLAG_DROP_BIT]) |-> $past(wr_en && paddr == ADDR_FLAGS);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag cleared without software");

  property p_drop_keeps_code;
    @(posedge clock) disable iff (!reset_n)
      drop_evt && !wr_en |=> $stable(threshold_code_r);
  endproperty
  a_drop_keeps_code: assert property (p_drop_keeps_code)
    else $error("threshold changed by supply-drop reset");

  property p_wdog_halt_flags;
    @(posedge clock) disable iff (!reset_n)
      wdog_halt |=> timeout_flag && power_down_flag && !chip_reset && core_clear;
  endproperty
  a_wdog_halt_flags: assert property (p_wdog_halt_flags)
    else $error("halted watchdog reset wrong");

  property p_wdog_run;
    @(posedge clock) disable iff (!reset_n)
      wdog_run |=> timeout_flag && chip_reset && pointer_clear;
  endproperty
  a_wdog_run: assert property (p_wdog_run)
    else $error("running watchdog reset wrong");

  property p_drop_keeps_status;
    @(posedge clock) disable iff (!reset_n)
      drop_evt |=> $stable(timeout_flag) && $stable(power_down_flag);
  endproperty
  a_drop_keeps_status: assert property (p_drop_keeps_status)
    else $error("status flags moved on supply-drop reset");

  property p_invalid_sticky;
    @(posedge clock) disable iff (!reset_n)
      $fell(flags_r[FLAG_INVALID_BIT]) |-> $past(wr_en && paddr == ADDR_FLAGS);
  endproperty
  a_invalid_sticky: assert property (p_invalid_sticky)
    else $error("invalid-code flag cleared without software");

  // The idle cycle after the pulse lets the core leave reset before a new cause
  property p_pulse_len;
    @(posedge clock) disable iff (!reset_n)
      $rose(core_clear) |-> core_clear [*4] ##1 !core_clear;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse length wrong");

  property p_por_init;
    @(posedge clock) disable iff (!reset_n)
      power_on_init |-> chip_reset && pointer_clear && reset_kind == RST_POWERON;
  endproperty
  a_por_init: assert property (p_por_init)
    else $error("power-on pulse incomplete");

  property p_por_status;
    @(posedge clock) disable iff (!reset_n)
      power_on_init |-> !timeout_flag && !power_down_flag;
  endproperty
  a_por_status: assert property (p_por_status)
    else $error("status flags set during power-on");

  property p_invalid_fixed;
    @(posedge clock) disable iff (!reset_n)
      invalid_evt |=> code_valid;
  endproperty
  a_invalid_fixed: assert property (p_invalid_fixed)
    else $error("threshold code still invalid after reload");

  property p_halt_keeps_ptr;
    @(posedge clock) disable iff (!reset_n)
      wdog_halt |=> !pointer_clear && !power_on_init;
  endproperty
  a_halt_keeps_ptr: assert property (p_halt_keeps_ptr)
    else $error("pointers cleared by halted watchdog reset");

  property p_drop_irq;
    @(posedge clock) disable iff (!reset_n)
      drop_evt && irq_en_r[FLAG_DROP_BIT] && !wr_en |=> irq;
  endproperty
  a_drop_irq: assert property (p_drop_irq)
    else $error("enabled supply-drop interrupt missing");
endmodule // supply_drop_reset_control
`default_nettype wire

/* tb/sdr_supply_model.sv */
// Comparator stand-in that drives the low-supply indication
`timescale 1ns/1ps
`default_nettype none
module sdr_supply_model (
  input  wire logic clock,
  output logic      low_supply
);
  initial low_supply = 1'b0;

  // High means supply below threshold; held for whole oscillator periods
  task automatic dip(input int n);
    @(posedge clock);
    low_supply <= 1'b1;
    repeat (n) @(posedge clock);
    low_supply <= 1'b0;
  endtask
endmodule // sdr_supply_model
`default_nettype wire

/* tb/tb_supply_drop_reset_control.sv */
// Self-checking bench for the supply drop reset control block
`timescale 1ns/1ps
`default_nettype none
module tb_supply_drop_reset_control;
  import sdr_pkg::*;
  logic        clock, reset_n, psel, penable, pwrite, wdog_timeout, sl, cc_q, last_ptr;
  logic        pready, pslverr, low_supply, chip_reset, core_clear, pointer_clear;
  logic        power_on_init, timeout_flag, power_down_flag, irq, last_chip, last_por;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  c;
  logic [7:0]  codes [4];
  logic [3:0]  pstrb;
  logic [1:0]  op_mode, threshold_level, w;
  logic [2:0]  reset_kind, last_kind;
  int          err_total = 0, comparisons = 0, pulses = 0, cyc = 0, last_cyc, t0, n;

  supply_drop_reset_control dut_u (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .low_supply, .op_mode, .wdog_timeout,
    .chip_reset, .core_clear, .pointer_clear, .power_on_init, .reset_kind, .timeout_flag,
    .power_down_flag, .threshold_level, .irq);
  sdr_supply_model model_u (.clock, .low_supply);

  always #50 clock = ~clock;

  // Records the start of every reset pulse, whatever its kind
  always @(posedge clock) begin
    cyc <= cyc + 1;
    cc_q <= core_clear;
    if (core_clear === 1'b1 && cc_q !== 1'b1) begin
      pulses <= pulses + 1;
      last_kind <= reset_kind;
      last_ptr <= pointer_clear;
      last_chip <= chip_reset;
      last_por <= power_on_init;
      last_cyc <= cyc;
    end
  end

  task automatic tally_and_finish();
    $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  function automatic int wp(input logic [1:0] code);
    return (code == 2'h0) ? 8 : (code == 2'h1) ? 32 : (code == 2'h2) ? 64 : 128;
  endfunction

  initial begin
    // Whole run is under 2000 cycles; the 20000-cycle limit covers the long width codes
    #(20000 * 100);
    err_total++;
    tally_and_finish();
  end

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    op_mode = MODE_FAST;
    wdog_timeout = 1'b0;
    codes = '{THRESH_V0, THRESH_V1, THRESH_V2, THRESH_V3};
    n = $urandom(32'h9282);
    tick(12);
    reset_n <= 1'b1;
    @(negedge clock);
    chk(power_on_init, 1, "power-on init");
    chk(reset_kind, RST_POWERON, "power-on kind");
    chk({timeout_flag, power_down_flag}, 0, "status after power-on");
    tick(8);
    rdc(ADDR_THRESH, THRESH_RESET, "threshold at power-on");
    rdc(ADDR_WIDTH, WIDTH_RESET, "width at power-on");
    rdc(ADDR_FLAGS, 0, "flags at power-on");
    rdc(12'h020, 0, "unmapped read");
    chk(sl, 1, "unmapped error");
    wr(12'h020, 32'hff);
    pstrb <= 4'he;
    wr(ADDR_WIDTH, 32'h3);
    pstrb <= 4'hf;
    rdc(ADDR_WIDTH, WIDTH_RESET, "write without strobe ignored");
    n = pulses;
    foreach (codes[i]) begin
      wr(ADDR_THRESH, codes[i]);
      rdc(ADDR_THRESH, codes[i], "threshold code");
      chk(threshold_level, i, "threshold level");
    end
    repeat (6) begin
      w = 2'($urandom % 4);
      wr(ADDR_WIDTH, w);
      model_u.dip($urandom_range(wp(w) - 3, 1));
      tick(6);
    end
    chk(pulses, n, "no reset from valid codes or short dips");
    // Just under the width must pass; the full width must reset once
    for (int k = 0; k < 4; k++) begin
      w = 2'(k);
      wr(ADDR_WIDTH, w);
      n = pulses;
      model_u.dip(wp(w) - 2);
      tick(8);
      chk(pulses, n, "dip just under width");
      model_u.dip(wp(w));
      tick(10);
      chk(pulses - n, 1, "dip of full width");
      chk(last_kind, RST_DROP, "full width kind");
      chk(last_chip, 1, "full width chip reset");
    end
    wr(ADDR_WIDTH, 0);
    wr(ADDR_IRQ_EN, 7);
    rdc(ADDR_IRQ_EN, 7, "enable readback");
    for (int m = 0; m < 4; m++) begin
      op_mode <= 2'(m);
      n = pulses;
      t0 = cyc;
      model_u.dip(12);
      tick(20);
      chk(pulses - n, m < 2, "drop reset by mode");
      if (m < 2) begin
        chk(last_kind, RST_DROP, "drop kind");
        // Dip launch, two sync flops, event register and pulse edge add five
        chk(last_cyc - t0, wp(2'h0) + 5, "drop width");
      end
    end
    rdc(ADDR_FLAGS, 4, "drop flag");
    rdc(ADDR_THRESH, THRESH_V3, "threshold kept over drop");
    chk({timeout_flag, power_down_flag}, 0, "status kept over drop");
    chk(irq, 1, "drop interrupt");
    wr(ADDR_IRQ_EN, 0);
    @(negedge clock);
    chk(irq, 0, "masked interrupt");
    wr(ADDR_IRQ_EN, 4);
    @(negedge clock);
    chk(irq, 1, "unmasked interrupt");
    wr(ADDR_IRQ_CLR, 4);
    @(negedge clock);
    chk(irq, 0, "cleared interrupt");
    rdc(ADDR_IRQ_STAT, 0, "status after clear");
    wr(ADDR_FLAGS, 4);
    rdc(ADDR_FLAGS, 4, "one keeps flag");
    wr(ADDR_FLAGS, 0);
    rdc(ADDR_FLAGS, 0, "zero clears flag");
    op_mode <= MODE_FAST;
    do c = 8'($urandom); while (c inside {THRESH_V0, THRESH_V1, THRESH_V2, THRESH_V3});
    n = pulses;
    wr(ADDR_THRESH, c);
    tick(20);
    chk(pulses - n, 1, "invalid code reset");
    chk(last_kind, RST_INVALID, "invalid kind");
    rdc(ADDR_FLAGS, 2, "invalid flag");
    rdc(ADDR_THRESH, THRESH_RESET, "threshold restored");
    for (int m = 0; m < 4; m++) begin
      op_mode <= 2'(m);
      @(posedge clock);
      wdog_timeout <= 1'b1;
      @(posedge clock);
      wdog_timeout <= 1'b0;
      tick(12);
      chk(last_kind, m < 2 ? RST_WDOG : RST_WDOG_HLT, "watchdog kind");
      chk(last_ptr, m < 2, "pointer clear");
      chk({timeout_flag, power_down_flag}, {1'b1, m >= 2}, "watchdog status");
      chk(last_chip, m < 2, "watchdog chip reset");
      chk(last_por, 0, "no power-on init on watchdog");
      rdc(ADDR_STATUS, {m >= 2, 1'b1}, "status register");
    end
    rdc(ADDR_THRESH, THRESH_RESET, "threshold kept over watchdog");
    rdc(ADDR_IRQ_STAT, 3, "interrupt causes");
    wr(ADDR_THRESH, THRESH_V2);
    reset_n <= 1'b0;
    tick(12);
    reset_n <= 1'b1;
    @(negedge clock);
    chk({timeout_flag, power_down_flag}, 0, "status after second power-on");
    chk(power_on_init, 1, "second power-on init");
    rdc(ADDR_THRESH, THRESH_RESET, "threshold after second power-on");
    rdc(ADDR_FLAGS, 0, "flags after second power-on");
    tally_and_finish();
  end
endmodule // tb_supply_drop_reset_control
`default_nettype wire
